/* verilog/rlomix_bank.v */
// register bank for the right line-output mixer: routing, volume, level, mute and power status
// How it works
// - bit7 routes left amp pair into output
// - bit7 routes left converter into output
// - bit7 routes second right input pair
// - bit7 routes right amp pair into output
// - bit7 routes right converter into output
// - volume codes and route bits reset zero
// - bits7-4 set gain 0..9 dB
// - bit3 low mutes, resets muted
// - bit1 shows gain pending, resets one
// - line output power in two places
// - power bit7 reports left converter up
// - power bit6 reports right converter up
// - power bit5 reports mono driver up
// - power bit4 reports left line pair
// - power bit2 reports left headphone up
// - power bit1 reports right headphone up
// - power status sits at index 94
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "rlomix_consts.vh"

module rlomix_bank (
    input  wire        mclk_i,            // 10 MHz clock
    input  wire        resetn_i,          // synchronous reset, active low
    input  wire        psel_i,            // apb select
    input  wire        penable_i,         // apb access phase
    input  wire        pwrite_i,          // apb direction, high writes
    input  wire [11:0] paddr_i,           // apb byte address
    input  wire [31:0] pwdata_i,          // apb write data
    input  wire [3:0]  pstrb_i,           // apb byte strobes
    output reg  [31:0] prdata_o,          // apb read data
    output reg         pready_o,          // apb ready
    output reg         pslverr_o,         // apb error on unmapped address
    input  wire        left_conv_up_i,    // left converter fully powered
    input  wire        right_conv_up_i,   // right converter fully powered
    input  wire        mono_out_up_i,     // mono driver powered
    input  wire        left_line_out_up_i,// left line pair powered
    input  wire        left_hp_up_i,      // left headphone driver powered
    input  wire        right_hp_up_i,     // right headphone driver powered
    output reg  [4:0]  route_en_o,        // route enables: lamp, lconv, line2r, ramp, rconv
    output reg  [34:0] route_vol_o,       // five applied 7-bit volumes, lamp in low bits
    output reg  [3:0]  out_gain_o,        // applied output gain code
    output reg         out_unmute_o,      // high lets the output pass
    output reg         out_power_o        // right line output driver powered
);

    // timing counts derived from the clock period; settle rounds down, power-up rounds up
    localparam integer SETTLE_INT = `RLOMIX_SETTLE_NS / `RLOMIX_CLK_NS;
    localparam integer PWRUP_INT  = (`RLOMIX_PWRUP_NS + `RLOMIX_CLK_NS - 1) / `RLOMIX_CLK_NS;
    // counters are 8 bits wide; both counts fit, so the slice drops only zero bits
    localparam [7:0]   SETTLE_CYC = SETTLE_INT[7:0];
    localparam [7:0]   PWRUP_CYC  = PWRUP_INT[7:0];

    // one-hot power sequencer states
    localparam [2:0] ST_OFF  = 3'b001;
    localparam [2:0] ST_RAMP = 3'b010;
    localparam [2:0] ST_ON   = 3'b100;

    reg  [7:0]  src_q [0:4];              // programmed route/volume bytes
    reg  [3:0]  gain_q;                   // programmed gain code
    reg         unmute_q;                 // programmed mute control
    reg         pend_q;                   // a programmed gain is not applied yet
    reg  [7:0]  settle_q;                 // settling countdown
    reg         pwr_req_q;                // software requests driver power
    reg  [2:0]  pst_q;                    // power sequencer state
    reg  [7:0]  pcnt_q;                   // power-up countdown
    reg  [7:0]  pst_byte_q;               // registered power status byte
    reg  [31:0] rdata_d;                  // read mux result
    reg         hit_d;                    // address is mapped
    integer     i;                        // loop index of the register process
    integer     j;                        // loop index of the output process

    // true when the apb address names a given register index
    function hit;
        input [11:0] addr;
        input [7:0]  idx;
        begin
            hit = (addr[1:0] == 2'b00) && (addr[11:2] == {2'b00, idx});
        end
    endfunction

    wire acc  = psel_i & penable_i & pready_o;    // access completes this edge
    wire wr   = acc & pwrite_i & pstrb_i[0];      // low byte is written
    wire pwr_up = (pst_q == ST_ON);               // driver fully up

    // read mux; reserved bits read as zero
    always @* begin
        rdata_d = 32'h0000_0000;
        hit_d   = 1'b1;
        if (hit(paddr_i, `RLOMIX_IDX_LAMP))
            rdata_d[7:0] = src_q[0];
        else if (hit(paddr_i, `RLOMIX_IDX_LCONV))
            rdata_d[7:0] = src_q[1];
        else if (hit(paddr_i, `RLOMIX_IDX_LINE2R))
            rdata_d[7:0] = src_q[2];
        else if (hit(paddr_i, `RLOMIX_IDX_RAMP))
            rdata_d[7:0] = src_q[3];
        else if (hit(paddr_i, `RLOMIX_IDX_RCONV))
            rdata_d[7:0] = src_q[4];
        else if (hit(paddr_i, `RLOMIX_IDX_LEVEL))
            rdata_d[7:0] = {gain_q, unmute_q, 1'b0, pend_q, pwr_up};
        else if (hit(paddr_i, `RLOMIX_IDX_PWR))
            rdata_d[7:0] = pst_byte_q;
        else if (hit(paddr_i, `RLOMIX_IDX_PWRCTL))
            rdata_d[7:0] = {7'h00, pwr_req_q};
        else
            hit_d = 1'b0;                         // unmapped address
    end

    // apb slave: one wait state, ready pulses in the access phase
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & ~hit_d;
            if (psel_i & penable_i & ~pready_o & ~pwrite_i)
                prdata_o <= rdata_d;
        end
    end

    // writable registers; read-only bits simply have no write path
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            for (i = 0; i < 5; i = i + 1)
                src_q[i] <= `RLOMIX_ROUTE_RST;
            gain_q    <= `RLOMIX_GAIN_RST;
            unmute_q  <= 1'b0;
            pwr_req_q <= 1'b0;
        end else if (wr) begin
            if (hit(paddr_i, `RLOMIX_IDX_LAMP))   src_q[0] <= pwdata_i[7:0];
            if (hit(paddr_i, `RLOMIX_IDX_LCONV))  src_q[1] <= pwdata_i[7:0];
            if (hit(paddr_i, `RLOMIX_IDX_LINE2R)) src_q[2] <= pwdata_i[7:0];
            if (hit(paddr_i, `RLOMIX_IDX_RAMP))   src_q[3] <= pwdata_i[7:0];
            if (hit(paddr_i, `RLOMIX_IDX_RCONV))  src_q[4] <= pwdata_i[7:0];
            if (hit(paddr_i, `RLOMIX_IDX_LEVEL)) begin
                gain_q   <= pwdata_i[`RLOMIX_GAIN_MSB:`RLOMIX_GAIN_LSB];
                unmute_q <= pwdata_i[`RLOMIX_MUTEN_BIT];
            end
            if (hit(paddr_i, `RLOMIX_IDX_PWRCTL)) pwr_req_q <= pwdata_i[0];
        end
    end

    // any write touching a gain of this output restarts settling
    wire gain_wr = wr & (hit(paddr_i, `RLOMIX_IDX_LAMP) | hit(paddr_i, `RLOMIX_IDX_LCONV) |
                         hit(paddr_i, `RLOMIX_IDX_LINE2R) | hit(paddr_i, `RLOMIX_IDX_RAMP) |
                         hit(paddr_i, `RLOMIX_IDX_RCONV) | hit(paddr_i, `RLOMIX_IDX_LEVEL));

    // pending flag: set by a gain write, wins over the settle clear
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            pend_q   <= 1'b1;
            settle_q <= SETTLE_CYC;
        end else if (gain_wr) begin
            pend_q   <= 1'b1;
            settle_q <= SETTLE_CYC;
        end else if (settle_q != 8'h00) begin
            settle_q <= settle_q - 8'h01;
        end else begin
            pend_q   <= 1'b0;
        end
    end

    // applied gains move to the outputs when settling ends
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            route_en_o   <= 5'h00;
            route_vol_o  <= 35'h0;
            out_gain_o   <= `RLOMIX_GAIN_RST;
            out_unmute_o <= 1'b0;
        end else begin
            out_unmute_o <= unmute_q;             // mute acts at once to avoid pops
            for (j = 0; j < 5; j = j + 1)
                route_en_o[j] <= src_q[j][`RLOMIX_ROUTE_BIT];
            if (!gain_wr && settle_q == 8'h00) begin
                for (j = 0; j < 5; j = j + 1)
                    route_vol_o[j*7 +: 7] <= src_q[j][`RLOMIX_VOL_MSB:0];
                // reserved codes are clamped; their gain is undefined anyway
                out_gain_o <= (gain_q > `RLOMIX_GAIN_MAX) ? `RLOMIX_GAIN_MAX : gain_q;
            end
        end
    end

    // driver power sequencer; a limitation: down is immediate, no ramp modelled
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            pst_q  <= ST_OFF;
            pcnt_q <= 8'h00;
        end else begin
            case (pst_q)
                ST_OFF: begin
                    if (pwr_req_q) begin
                        pst_q  <= ST_RAMP;
                        pcnt_q <= PWRUP_CYC;
                    end
                end
                ST_RAMP: begin
                    if (!pwr_req_q)
                        pst_q <= ST_OFF;
                    else if (pcnt_q == 8'h01)
                        pst_q <= ST_ON;
                    pcnt_q <= pcnt_q - 8'h01;
                end
                ST_ON: begin
                    if (!pwr_req_q)
                        pst_q <= ST_OFF;
                end
                default: pst_q <= ST_OFF;
            endcase
        end
    end

    // power status byte and driver output
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            pst_byte_q  <= 8'h00;
            out_power_o <= 1'b0;
        end else begin
            out_power_o <= pwr_up;
            pst_byte_q  <= {left_conv_up_i,
                            right_conv_up_i,
                            mono_out_up_i,
                            left_line_out_up_i,
                            pwr_up,
                            left_hp_up_i,
                            right_hp_up_i,
                            1'b0};
        end
    end

endmodule // rlomix_bank

/* verilog/rlomix_consts.vh */
// offsets, field positions, reset values and timing in ns of the right line-out mixer register bank
`ifndef RLOMIX_CONSTS_VH
`define RLOMIX_CONSTS_VH

// register indices as printed; byte address is four times the index
`define RLOMIX_IDX_LAMP      8'h58
`define RLOMIX_IDX_LCONV     8'h59
`define RLOMIX_IDX_LINE2R    8'h5a
`define RLOMIX_IDX_RAMP      8'h5b
`define RLOMIX_IDX_RCONV     8'h5c
`define RLOMIX_IDX_LEVEL     8'h5d
`define RLOMIX_IDX_PWR       8'h5e
`define RLOMIX_IDX_PWRCTL    8'h60

// route/volume field layout
`define RLOMIX_ROUTE_BIT     7
`define RLOMIX_VOL_MSB       6
`define RLOMIX_ROUTE_RST     8'h00

// level register layout
`define RLOMIX_GAIN_MSB      7
`define RLOMIX_GAIN_LSB      4
`define RLOMIX_MUTEN_BIT     3
`define RLOMIX_PEND_BIT      1
`define RLOMIX_PWR_BIT       0
`define RLOMIX_GAIN_RST      4'h0
`define RLOMIX_GAIN_MAX      4'h9

// power status layout
`define RLOMIX_PS_LCONV      7
`define RLOMIX_PS_RCONV      6
`define RLOMIX_PS_MONO       5
`define RLOMIX_PS_LLINE      4
`define RLOMIX_PS_RLINE      3
`define RLOMIX_PS_LHP        2
`define RLOMIX_PS_RHP        1

// timing: gain settling and driver power-up, in ns
`define RLOMIX_SETTLE_NS     2000
`define RLOMIX_PWRUP_NS      5000
`define RLOMIX_CLK_NS        100

`endif

/* testbench/rlomix_checker.sv */
// port assertions for the right line-out mixer register bank
`timescale 1ns/1ps
module rlomix_checker (
    input wire logic        mclk_i, resetn_i, psel_i, penable_i, pwrite_i, // clock, reset, apb controls
    input wire logic [11:0] paddr_i,                                       // apb byte address
    input wire logic [31:0] prdata_o,                                      // apb read data
    input wire logic        pready_o, pslverr_o, out_unmute_o, out_power_o, // answers and level outputs
    input wire logic        left_conv_up_i, right_conv_up_i, mono_out_up_i, // converter and mono driver status
    input wire logic        left_line_out_up_i, left_hp_up_i, right_hp_up_i, // driver status
    input wire logic [4:0]  route_en_o,                                    // applied route enables
    input wire logic [3:0]  out_gain_o                                     // applied gain code
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    // exactly one wait state before ready
    property p_ready_wait; psel_i && penable_i && !pready_o |=> pready_o; endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready not one cycle after access");
    // ready is a single-cycle pulse
    property p_ready_pulse; pready_o |=> !pready_o; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    // ready only while the master holds its access
    property p_ready_access; pready_o |-> psel_i && penable_i; endproperty
    a_ready_access: assert property (p_ready_access) else $error("ready outside access");
    // error only travels with ready
    property p_err_ready; pslverr_o |-> pready_o; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    // a misaligned access is refused, so nothing lands at the wrong place
    property p_misaligned; pready_o && paddr_i[1:0] != 2'b00 |-> pslverr_o; endproperty
    a_misaligned: assert property (p_misaligned) else $error("misaligned access accepted");
    // reset leaves nothing routed, output muted and powered down
    property p_reset_clear;
        disable iff (1'b0) !resetn_i |=> route_en_o == 5'h00 && out_gain_o == 4'h0 && !out_unmute_o && !out_power_o;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset");
    // applied gain never leaves 0..9 db
    property p_gain_range; out_gain_o <= 4'h9; endproperty
    a_gain_range: assert property (p_gain_range) else $error("gain beyond 9 db");
    // registers are one byte wide
    property p_rdata_upper; pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h000000; endproperty
    a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");
    // status byte mirrors the converter and driver inputs, reserved bit low
    property p_pwr_read;
        pready_o && !pwrite_i && paddr_i == 12'h178 |-> {prdata_o[7:4], prdata_o[2:0]} ==
            {left_conv_up_i, right_conv_up_i, mono_out_up_i, left_line_out_up_i, left_hp_up_i, right_hp_up_i, 1'b0};
    endproperty
    a_pwr_read: assert property (p_pwr_read) else $error("power status read wrong");
endmodule // rlomix_checker
bind rlomix_bank rlomix_checker rlomix_checker_inst (.*);

/* testbench/testbench.sv */
// self-checking bench for the right line-out mixer register bank
`timescale 1ns/1ps
module testbench;
    localparam logic [11:0] BASE = 12'h160; // byte address of the first route register
    logic        mclk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, err;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o, rd;
    logic [3:0]  pstrb_i = 4'hf;           // only full-word writes are issued
    logic        left_conv_up_i = 0, right_conv_up_i = 0, mono_out_up_i = 0;
    logic        left_line_out_up_i = 0, left_hp_up_i = 0, right_hp_up_i = 0;
    logic        pready_o, pslverr_o, out_unmute_o, out_power_o;
    logic [4:0]  route_en_o;
    logic [34:0] route_vol_o;
    logic [3:0]  out_gain_o;
    logic [5:0]  pats [2] = '{6'h29, 6'h16}; // status input patterns
    logic [5:0]  p;
    int          n_fail = 0, tests_run = 0;
    rlomix_bank rlomix_bank_inst (.*);
    // 10 mhz clock
    initial forever #50 mclk_i = ~mclk_i;
    // one apb transfer; bounded wait so a dead slave cannot hang us
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        @(posedge mclk_i);
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
        @(posedge mclk_i);
        penable_i <= 1'b1;
        t = 0;
        do @(posedge mclk_i); while (pready_o !== 1'b1 && ++t < 50);
        if (t >= 50) n_fail++;
        rd = prdata_o;
        err = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
    endtask
    // compare seen against expected
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic give_verdict;
        if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #(100 * 20000);
        n_fail++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge mclk_i);
        resetn_i <= 1'b1;
        // pending reads one straight after reset, before the settle count runs out
        apb(0, BASE + 12'h014, 0);
        chk("reset pending", rd, 32'h02);
        // reset values of every register but the power control; pending has cleared by the time level is read again
        for (int i = 0; i < 7; i++) begin
            apb(0, BASE + 12'(4 * i), 0);
            chk("reset value", rd, 32'h00);
        end
        // route on every source with a distinct volume
        for (int i = 0; i < 5; i++) apb(1, BASE + 12'(4 * i), 32'h80 | 32'(8'h11 * (i + 1)));
        apb(0, BASE + 12'h014, 0);
        chk("pending", rd, 32'h02);
        for (int i = 0; i < 5; i++) begin
            apb(0, BASE + 12'(4 * i), 0);
            chk("route readback", rd, 32'h80 | 32'(8'h11 * (i + 1)));
        end
        repeat (25) @(posedge mclk_i);
        chk("route_en", 32'(route_en_o), 32'h1f);
        chk("route_vol", route_vol_o[31:0], {4'h5, 7'h44, 7'h33, 7'h22, 7'h11});
        chk("route_vol hi", 32'(route_vol_o[34:28]), 32'h55);
        // gain 9, unmute, pending and power status bits attempted; one source cut
        apb(1, BASE + 12'h014, 32'h9b);
        apb(1, BASE + 12'h004, 32'h22);
        repeat (25) @(posedge mclk_i);
        apb(0, BASE + 12'h014, 0);
        chk("level", rd, 32'h98);
        chk("route_en cut", 32'(route_en_o), 32'h1d);
        chk("gain", 32'(out_gain_o), 32'h9);
        chk("unmute", 32'(out_unmute_o), 32'h1);
        // status inputs show through; writes to the status byte are dropped
        foreach (pats[k]) begin
            p = pats[k];
            {left_conv_up_i, right_conv_up_i, mono_out_up_i, left_line_out_up_i, left_hp_up_i, right_hp_up_i} <= p;
            apb(1, BASE + 12'h018, 32'hfe);
            apb(0, BASE + 12'h018, 0);
            chk("power status", rd, 32'({p[5:2], 1'b0, p[1:0], 1'b0}));
        end
        // line driver power-up shows in both places
        apb(1, 12'h180, 32'h1);
        repeat (60) @(posedge mclk_i);
        apb(0, BASE + 12'h014, 0);
        chk("level powered", rd, 32'h99);
        apb(0, BASE + 12'h018, 0);
        chk("status powered", rd, 32'({p[5:2], 1'b1, p[1:0], 1'b0}));
        chk("out_power", 32'(out_power_o), 32'h1);
        // unmapped and misaligned accesses are refused and change nothing
        apb(0, 12'h1c0, 0);
        chk("unmapped err", 32'(err), 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1, BASE + 12'h001, 32'h00);
        chk("misaligned err", 32'(err), 32'h1);
        apb(0, BASE, 0);
        chk("lamp kept", rd, 32'h91);
        give_verdict();
    end
endmodule // testbench
